// file: common/lin_uart_pkg.sv
// package: register map, field positions and timing constants
package lin_uart_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_BAUD_CTRL = 8'h00;
   localparam logic [7:0] OFS_TX_CTRL = 8'h04;
   localparam logic [7:0] OFS_RX_CTRL = 8'h08;
   localparam logic [7:0] OFS_DIV_LO = 8'h0C;
   localparam logic [7:0] OFS_DIV_HI = 8'h10;
   localparam logic [7:0] OFS_TX_DATA = 8'h14;
   localparam logic [7:0] OFS_RX_DATA = 8'h18;
   localparam logic [7:0] OFS_FLAGS = 8'h1C;
   localparam int BC_AUTOBAUD = 0;
   localparam int BC_WAKE = 1;
   localparam int BC_DIV16 = 3;
   localparam int BC_RX_IDLE = 6;
   localparam int BC_OVF = 7;
   localparam int TC_SHIFT_EMPTY = 1;
   localparam int TC_HIGH_SPEED = 2;
   localparam int TC_SEND_BREAK = 3;
   localparam int TC_SYNC = 4;
   localparam int TC_TX_EN = 5;
   localparam int RC_FRAMING_ERROR_FLAG = 2;
   localparam int RC_RX_EN = 4;
   localparam int RC_PORT_EN = 7;
   localparam int FL_RX = 0;
   localparam int FL_TXE = 1;
   localparam logic [15:0] RST_DIVISOR = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [8:0] BASE_MASK_SLOW = 9'h03F;
   localparam logic [8:0] BASE_MASK_MID = 9'h00F;
   localparam logic [8:0] BASE_MASK_FAST = 9'h003;
   localparam logic [8:0] ABD_MASK_SLOW = 9'h1FF;
   localparam logic [8:0] ABD_MASK_MID = 9'h07F;
   localparam logic [8:0] ABD_MASK_FAST = 9'h01F;
   localparam logic [3:0] CHAR_FRAME_BITS = 4'hA;
   localparam logic [3:0] BREAK_FRAME_BITS = 4'hE;
   localparam logic [2:0] ABD_LAST_RISE = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hw/lin_uart.sv
`timescale 1ns/1ps
// lin_uart: auto-baud, wake-on-break and break transmit behind axi4-lite
module lin_uart
   import lin_uart_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic receive_line,
   output logic tx_line,
   output logic rx_interrupt_flag,
   output logic tx_buffer_empty_flag
);

////////////////////////////////////////////////////////////////////////////
typedef enum logic [3:0]
{
   AB_IDLE = 4'b0001,
   AB_START = 4'b0010,
   AB_FIRST = 4'b0100,
   AB_COUNT = 4'b1000
} ab_state_t;

typedef enum logic [1:0]
{
   WK_WATCH = 2'b01,
   WK_LOW = 2'b10
} wk_state_t;

typedef enum logic [3:0]
{
   RX_IDLE = 4'b0001,
   RX_START = 4'b0010,
   RX_DATA = 4'b0100,
   RX_STOP = 4'b1000
} rx_state_t;

typedef enum logic [1:0]
{
   TX_IDLE = 2'b01,
   TX_SHIFT = 2'b10
} tx_state_t;

typedef struct packed
{
   logic awready;
   logic wready;
   logic bvalid;
   logic [1:0] bresp;
   logic arready;
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic aw_got;
   logic w_got;
   logic [7:0] waddr;
   logic [7:0] wbyte;
   logic wlane;
   logic rx_s1;
   logic rx_s2;
   logic rx_s3;
   logic [8:0] pre;
   logic ab_en;
   logic wake_en;
   logic div16;
   logic hspeed;
   logic send_brk;
   logic sync_mode;
   logic tx_en;
   logic port_en;
   logic rx_en;
   logic ovf;
   logic [15:0] div;
   logic rx_flag;
   logic framing_error_flag;
   logic [7:0] rx_data;
   ab_state_t ab_st;
   logic [15:0] ab_cnt;
   logic [2:0] ab_rises;
   wk_state_t wk_st;
   rx_state_t rx_st;
   logic [16:0] rx_cnt;
   logic [2:0] rx_bit;
   logic [7:0] rx_sh;
   tx_state_t tx_st;
   logic [13:0] tx_sh;
   logic [3:0] tx_bits;
   logic [16:0] tx_cnt;
   logic tx_brk;
   logic [7:0] txbuf;
   logic txbuf_full;
   logic tx_line;
} state_t;

state_t s_q;
state_t s_d;
logic rise;
logic fall;
logic base_tick;
logic abd_tick;
logic [8:0] base_mask;
logic [8:0] abd_mask;
logic [15:0] eff_div;
logic [16:0] bit_len;
logic [16:0] half_len;
logic rx_on;
logic ar_fire;
logic wr_fire;
logic [32:0] rd_res;
logic [7:0] wr_ofs;
logic ab_wrap;

////////////////////////////////////////////////////////////////////////////
// edges only from the second and third stages; first stage feeds nothing else
assign rise = s_q.rx_s2 & ~s_q.rx_s3;
assign fall = ~s_q.rx_s2 & s_q.rx_s3;

// base clock /64, /16, /16, /4; auto-baud clock eight times slower
always_comb
begin
   case ({s_q.div16, s_q.hspeed})
      2'b00:
      begin
         base_mask = BASE_MASK_SLOW;
         abd_mask = ABD_MASK_SLOW;
      end
      2'b11:
      begin
         base_mask = BASE_MASK_FAST;
         abd_mask = ABD_MASK_FAST;
      end
      default:
      begin
         base_mask = BASE_MASK_MID;
         abd_mask = ABD_MASK_MID;
      end
   endcase
end

assign base_tick = (s_q.pre & base_mask) == base_mask;
assign abd_tick = (s_q.pre & abd_mask) == abd_mask;
assign eff_div = s_q.div16 ? s_q.div : {8'h00, s_q.div[7:0]};
assign bit_len = {1'b0, eff_div} + 17'h00001;
assign half_len = (bit_len[16:1] == 16'h0000) ? 17'h00001
                  : {1'b0, bit_len[16:1]};
// auto-baud and wake both hold the receiver idle
assign rx_on = s_q.port_en & s_q.rx_en & ~s_q.sync_mode
               & ~s_q.ab_en & ~s_q.wake_en;
assign ar_fire = arvalid & s_q.arready;
assign wr_fire = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
assign wr_ofs = {s_q.waddr[7:2], 2'b00};
// a wrap in the cycle of a clearing write still sets the overflow bit
assign ab_wrap = (s_q.ab_st == AB_COUNT) && abd_tick
                 && (s_q.ab_cnt == 16'hFFFF);

function automatic logic [32:0] read_reg(input state_t s,
                                         input logic [7:0] a);
   logic [7:0] v;
   logic ok;
   v = RST_BYTE;
   ok = 1'b1;
   case ({a[7:2], 2'b00})
      OFS_BAUD_CTRL:
      begin
         v[BC_AUTOBAUD] = s.ab_en;
         v[BC_WAKE] = s.wake_en;
         v[BC_DIV16] = s.div16;
         v[BC_RX_IDLE] = s.rx_st == RX_IDLE;
         v[BC_OVF] = s.ovf;
      end
      OFS_TX_CTRL:
      begin
         v[TC_SHIFT_EMPTY] = s.tx_st == TX_IDLE;
         v[TC_HIGH_SPEED] = s.hspeed;
         v[TC_SEND_BREAK] = s.send_brk;
         v[TC_SYNC] = s.sync_mode;
         v[TC_TX_EN] = s.tx_en;
      end
      OFS_RX_CTRL:
      begin
         v[RC_FRAMING_ERROR_FLAG] = s.framing_error_flag;
         v[RC_RX_EN] = s.rx_en;
         v[RC_PORT_EN] = s.port_en;
      end
      OFS_DIV_LO: v = s.div[7:0];
      OFS_DIV_HI: v = s.div[15:8];
      OFS_TX_DATA: v = RST_BYTE;
      OFS_RX_DATA: v = s.rx_data;
      OFS_FLAGS:
      begin
         v[FL_RX] = s.rx_flag;
         v[FL_TXE] = ~s.txbuf_full;
      end
      default: ok = 1'b0;
   endcase
   return {ok, 24'h000000, v};
endfunction

assign rd_res = read_reg(s_q, araddr);

////////////////////////////////////////////////////////////////////////////
always_comb
begin
   s_d = s_q;
   s_d.rx_s1 = receive_line;
   s_d.rx_s2 = s_q.rx_s1;
   s_d.rx_s3 = s_q.rx_s2;
   s_d.pre = s_q.pre + 9'h001;

   // bus read channel; data read clears the flag, a set below still wins
   if (ar_fire)
   begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_res[31:0];
      s_d.rresp = rd_res[32] ? RESP_OKAY : RESP_SLVERR;
      if ({araddr[7:2], 2'b00} == OFS_RX_DATA)
         s_d.rx_flag = 1'b0;
   end
   if (s_q.rvalid && rready)
   begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
   end

   // bus write channels, taken in either order
   if (awvalid && s_q.awready)
   begin
      s_d.awready = 1'b0;
      s_d.aw_got = 1'b1;
      s_d.waddr = awaddr;
   end
   if (wvalid && s_q.wready)
   begin
      s_d.wready = 1'b0;
      s_d.w_got = 1'b1;
      s_d.wbyte = wdata[7:0];
      s_d.wlane = wstrb[0];
   end
   if (s_q.bvalid && bready)
   begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // auto-baud: line edges time the divisor pair as one 16-bit counter
   case (s_q.ab_st)
      AB_IDLE:
         // with wake also set, wait for the break to end first
         if (s_q.ab_en && !s_q.wake_en)
            s_d.ab_st = AB_START;
      AB_START:
         if (fall)
            s_d.ab_st = AB_FIRST;
      AB_FIRST:
         if (rise)
         begin
            s_d.ab_st = AB_COUNT;
            s_d.ab_cnt = RST_DIVISOR;
            s_d.ab_rises = 3'h0;
         end
      AB_COUNT:
      begin
         if (abd_tick)
         begin
            s_d.ab_cnt = s_q.ab_cnt + 16'h0001;
            if (s_q.ab_cnt == 16'hFFFF)
               s_d.ovf = 1'b1;
         end
         if (rise)
         begin
            s_d.ab_rises = s_q.ab_rises + 3'h1;
            if (s_q.ab_rises == ABD_LAST_RISE)
            begin
               // eight bits at 1/8 rate: one bit time in base ticks
               s_d.div = s_d.ab_cnt;
               s_d.ab_en = 1'b0;
               s_d.rx_flag = 1'b1;
               s_d.ab_st = AB_IDLE;
            end
         end
      end
      default: s_d.ab_st = AB_IDLE;
   endcase
   if (!s_q.ab_en)
      s_d.ab_st = AB_IDLE;

   // wake-on-break, asynchronous mode only
   case (s_q.wk_st)
      WK_WATCH:
         if (s_q.wake_en && !s_q.sync_mode && fall)
         begin
            s_d.rx_flag = 1'b1;
            s_d.wk_st = WK_LOW;
         end
      WK_LOW:
         if (rise)
         begin
            s_d.wake_en = 1'b0;
            s_d.wk_st = WK_WATCH;
         end
      default: s_d.wk_st = WK_WATCH;
   endcase
   if (!s_q.wake_en || s_q.sync_mode)
      s_d.wk_st = WK_WATCH;

   ////////////////////////////////////////////////////////////////////////
   // receiver, sampling mid-bit; a break lands as 00h with framing error
   if (base_tick && s_q.rx_st != RX_IDLE)
      s_d.rx_cnt = s_q.rx_cnt - 17'h00001;
   case (s_q.rx_st)
      RX_IDLE:
         if (rx_on && fall)
         begin
            s_d.rx_st = RX_START;
            s_d.rx_cnt = half_len;
         end
      RX_START:
         if (base_tick && s_q.rx_cnt == 17'h00001)
         begin
            s_d.rx_cnt = bit_len;
            s_d.rx_bit = 3'h0;
            s_d.rx_st = s_q.rx_s2 ? RX_IDLE : RX_DATA;
         end
      RX_DATA:
         if (base_tick && s_q.rx_cnt == 17'h00001)
         begin
            s_d.rx_cnt = bit_len;
            s_d.rx_sh = {s_q.rx_s2, s_q.rx_sh[7:1]};
            s_d.rx_bit = s_q.rx_bit + 3'h1;
            if (s_q.rx_bit == 3'h7)
               s_d.rx_st = RX_STOP;
         end
      RX_STOP:
         if (base_tick && s_q.rx_cnt == 17'h00001)
         begin
            s_d.rx_data = s_q.rx_sh;
            s_d.framing_error_flag = ~s_q.rx_s2;
            s_d.rx_flag = 1'b1;
            s_d.rx_st = RX_IDLE;
         end
      default: s_d.rx_st = RX_IDLE;
   endcase
   // wake or auto-baud mid-frame drops the partial character
   if (!rx_on)
      s_d.rx_st = RX_IDLE;

   ////////////////////////////////////////////////////////////////////////
   // transmitter; break decided at load so a preloaded byte goes normally
   case (s_q.tx_st)
      TX_IDLE:
         if (s_q.txbuf_full && s_q.tx_en)
         begin
            s_d.txbuf_full = 1'b0;
            s_d.tx_st = TX_SHIFT;
            s_d.tx_cnt = bit_len;
            s_d.tx_brk = s_q.send_brk;
            if (s_q.send_brk)
            begin
               s_d.tx_sh = {1'b1, 13'h0000};
               s_d.tx_bits = BREAK_FRAME_BITS;
            end
            else
            begin
               s_d.tx_sh = {5'h1F, s_q.txbuf, 1'b0};
               s_d.tx_bits = CHAR_FRAME_BITS;
            end
         end
      TX_SHIFT:
      begin
         if (base_tick)
            s_d.tx_cnt = s_q.tx_cnt - 17'h00001;
         if (base_tick && s_q.tx_cnt == 17'h00001)
         begin
            s_d.tx_cnt = bit_len;
            s_d.tx_sh = {1'b1, s_q.tx_sh[13:1]};
            s_d.tx_bits = s_q.tx_bits - 4'h1;
            if (s_q.tx_bits == 4'h1)
            begin
               s_d.tx_st = TX_IDLE;
               if (s_q.tx_brk)
                  s_d.send_brk = 1'b0;
            end
         end
      end
      default: s_d.tx_st = TX_IDLE;
   endcase
   if (!s_q.tx_en)
      s_d.tx_st = TX_IDLE;

   ////////////////////////////////////////////////////////////////////////
   // register writes, low byte lane only
   if (wr_fire)
   begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (s_q.wlane)
      begin
         case (wr_ofs)
            OFS_BAUD_CTRL:
            begin
               s_d.ab_en = s_q.wbyte[BC_AUTOBAUD];
               s_d.wake_en = s_q.wbyte[BC_WAKE];
               s_d.div16 = s_q.wbyte[BC_DIV16];
               s_d.ovf = (s_q.wbyte[BC_OVF] & s_q.ovf) | ab_wrap;
            end
            OFS_TX_CTRL:
            begin
               s_d.hspeed = s_q.wbyte[TC_HIGH_SPEED];
               s_d.send_brk = s_q.wbyte[TC_SEND_BREAK];
               s_d.sync_mode = s_q.wbyte[TC_SYNC];
               s_d.tx_en = s_q.wbyte[TC_TX_EN];
            end
            OFS_RX_CTRL:
            begin
               s_d.rx_en = s_q.wbyte[RC_RX_EN];
               s_d.port_en = s_q.wbyte[RC_PORT_EN];
            end
            OFS_DIV_LO: s_d.div[7:0] = s_q.wbyte;
            OFS_DIV_HI: s_d.div[15:8] = s_q.wbyte;
            OFS_TX_DATA:
               // ignored with transmit off; value unused for a break
               if (s_q.tx_en)
               begin
                  s_d.txbuf = s_q.wbyte;
                  s_d.txbuf_full = 1'b1;
               end
            OFS_RX_DATA,
            OFS_FLAGS:
               s_d.bresp = RESP_OKAY;
            default: s_d.bresp = RESP_SLVERR;
         endcase
      end
      else if (wr_ofs > OFS_FLAGS)
         s_d.bresp = RESP_SLVERR;
   end

   s_d.tx_line = (s_d.tx_st == TX_SHIFT) ? s_d.tx_sh[0] : 1'b1;
end

////////////////////////////////////////////////////////////////////////////
always_ff @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
   begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.rx_s1 <= 1'b1;
      s_q.rx_s2 <= 1'b1;
      s_q.rx_s3 <= 1'b1;
      s_q.div <= RST_DIVISOR;
      s_q.ab_st <= AB_IDLE;
      s_q.wk_st <= WK_WATCH;
      s_q.rx_st <= RX_IDLE;
      s_q.tx_st <= TX_IDLE;
      s_q.tx_line <= 1'b1;
   end
   else
   begin
      s_q <= s_d;
   end
end

assign awready = s_q.awready;
assign wready = s_q.wready;
assign bvalid = s_q.bvalid;
assign bresp = s_q.bresp;
assign arready = s_q.arready;
assign rvalid = s_q.rvalid;
assign rdata = s_q.rdata;
assign rresp = s_q.rresp;
assign tx_line = s_q.tx_line;
assign rx_interrupt_flag = s_q.rx_flag;
assign tx_buffer_empty_flag = ~s_q.txbuf_full;

endmodule

// file: verif/lin_uart_sva.sv
`timescale 1ns/1ps
// checker: port-level properties of the lin uart
module lin_uart_sva
   import lin_uart_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic receive_line,
   input wire logic tx_line,
   input wire logic rx_interrupt_flag,
   input wire logic tx_buffer_empty_flag
);
   logic [ADDR_W-1:0] aw_q;
   logic wake_bit_q;
   logic wake_q;
   logic line_q;
   logic sync_bit_q;
   logic sync_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////
   // shadow of wake enable, loaded by baud-control writes, else cleared at any rise of the line
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aw_q <= '0;
         wake_bit_q <= 1'b0;
         wake_q <= 1'b0;
         line_q <= 1'b1;
         sync_bit_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         line_q <= receive_line;
         if (awvalid && awready)
            aw_q <= awaddr;
         if (wvalid && wready)
         begin
            wake_bit_q <= wdata[BC_WAKE];
            sync_bit_q <= wdata[TC_SYNC];
         end
         if (bvalid && bready && aw_q == OFS_TX_CTRL)
            sync_q <= sync_bit_q;
         if (bvalid && bready && aw_q == OFS_BAUD_CTRL)
            wake_q <= wake_bit_q;
         else if (receive_line && !line_q)
            wake_q <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////
   a_bvalid_hold: assert property (bvalid && !bready |=> bvalid
      && $stable(bresp)) else $error("write response dropped early");
   a_rvalid_hold: assert property (rvalid && !rready |=> rvalid
      && $stable(rdata)) else $error("read data dropped early");
   a_write_latency: assert property (awvalid && awready && wvalid
      && wready |-> ##2 bvalid) else $error("write answer late");
   a_read_latency: assert property (arvalid && arready |=> rvalid
      && !arready) else $error("read answer late");
   a_unmapped_read: assert property (arvalid && arready
      && araddr[7:2] > 6'h07 |=> rresp == RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   a_reset_idle: assert property ($rose(reset_n) |-> tx_line
      && !rx_interrupt_flag && tx_buffer_empty_flag)
      else $error("outputs not idle after reset");
   a_wake_flag: assert property (
      wake_q && !sync_q && $fell(receive_line)
      |-> ##[1:5] rx_interrupt_flag)
      else $error("no flag at wake edge");
   a_sync_no_wake: assert property (
      sync_q && wake_q && !rx_interrupt_flag && $fell(receive_line)
      |-> ##3 !rx_interrupt_flag)
      else $error("wake flagged in sync mode");
   a_read_clears: assert property (
      (receive_line [*6] ##0 arvalid && arready && araddr == OFS_RX_DATA)
      |=> !rx_interrupt_flag) else $error("data read left flag set");
   c_wake: cover property (wake_q && $fell(receive_line));
   c_flag: cover property ($rose(rx_interrupt_flag));
   c_unmapped: cover property (arvalid && arready && araddr[7:2] > 6'h07);
endmodule

bind lin_uart lin_uart_sva chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
   .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
   .receive_line(receive_line), .tx_line(tx_line),
   .rx_interrupt_flag(rx_interrupt_flag),
   .tx_buffer_empty_flag(tx_buffer_empty_flag));

// file: verif/lin_node_model.sv
`timescale 1ns/1ps
// remote lin node: drives the receive line, decodes the transmit line
module lin_node_model #(
   parameter int BIT_CYC = 640
)
(
   input wire logic clk_sys,
   input wire logic tx_line,
   output logic receive_line
);
   logic [8:0] got[$];
   logic [7:0] b;
   int low_run = 0;
   int max_low = 0;
   initial
      receive_line = 1'b1;
   ////////////////////////////////////////////////////////////
   task automatic hold(input logic v, input int n);
      receive_line <= v;
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic send_frame(input logic [7:0] d);
      hold(1'b0, BIT_CYC);
      for (int i = 0; i < 8; i++)
         hold(d[i], BIT_CYC);
      hold(1'b1, BIT_CYC);
   endtask
   // all-zero wake character, long enough for a lin bus
   task automatic send_low(input int bits);
      hold(1'b0, bits * BIT_CYC);
      hold(1'b1, 2 * BIT_CYC);
   endtask
   ////////////////////////////////////////////////////////////
   // mid-bit sampler; a break shows as 00 with a low stop bit
   initial
   begin
      forever
      begin
         @(negedge tx_line);
         repeat (BIT_CYC / 2) @(posedge clk_sys);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT_CYC) @(posedge clk_sys);
            b[i] = tx_line;
         end
         repeat (BIT_CYC) @(posedge clk_sys);
         got.push_back({tx_line, b});
         wait (tx_line === 1'b1);
      end
   end
   always @(posedge clk_sys)
   begin
      if (tx_line === 1'b0)
         low_run++;
      else
      begin
         if (low_run > max_low)
            max_low = low_run;
         low_run = 0;
      end
   end
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
// testbench: register-level sequences for auto-baud, wake and break
module testbench;
   import lin_uart_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] awaddr = '0;
   logic [7:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hF;
   logic [31:0] rdata;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic receive_line, tx_line, rx_interrupt_flag, tx_buffer_empty_flag;
   logic [7:0] d;
   int error_cnt = 0;
   int checks_done = 0;
   initial
      forever #50 clk_sys = ~clk_sys;
   lin_uart dut (.clk_sys(clk_sys), .reset_n(reset_n), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .receive_line(receive_line), .tx_line(tx_line),
      .rx_interrupt_flag(rx_interrupt_flag),
      .tx_buffer_empty_flag(tx_buffer_empty_flag));
   lin_node_model #(.BIT_CYC(640)) node (.clk_sys(clk_sys),
      .tx_line(tx_line), .receive_line(receive_line));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      // idle edge: a following call must not re-raise in this step
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (arready)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      d = rdata[7:0];
      r = rresp;
      rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk(d, e);
   endtask
   task automatic results();
      $display("mismatches %0d of %0d checks", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (90000) @(posedge clk_sys);
      error_cnt++;
      results();
   end
   initial
   begin
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      rc(OFS_BAUD_CTRL, 8'h40);
      rc(OFS_TX_CTRL, 8'h02);
      rc(OFS_FLAGS, 8'h02);
      rd(8'h20);
      chk(8'(r), 8'(RESP_SLVERR));
      chk(d, 8'h00);
      // bit time 640 clocks: (159 + 1) base ticks of clk/4
      wr(OFS_RX_CTRL, 8'h90);
      wr(OFS_TX_CTRL, 8'h04);
      wr(OFS_BAUD_CTRL, 8'h08);
      wr(OFS_DIV_LO, 8'h9F);
      wr(OFS_DIV_HI, 8'h00);
      // no byte lane: the write is answered but changes nothing
      wstrb <= 4'h0;
      wr(OFS_DIV_LO, 8'h55);
      wstrb <= 4'hF;
      chk(8'(r), 8'(RESP_OKAY));
      rc(OFS_DIV_LO, 8'h9F);
      wr(8'h20, 8'h00);
      chk(8'(r), 8'(RESP_SLVERR));
      node.send_low(13);
      chk(8'(rx_interrupt_flag), 8'h01);
      rc(OFS_RX_CTRL, 8'h94);
      rc(OFS_RX_DATA, 8'h00);
      chk(8'(rx_interrupt_flag), 8'h00);
      // sync mode: wake must ignore the line
      wr(OFS_TX_CTRL, 8'h14);
      wr(OFS_BAUD_CTRL, 8'h0A);
      node.send_low(13);
      chk(8'(rx_interrupt_flag), 8'h00);
      rc(OFS_BAUD_CTRL, 8'h4A);
      wr(OFS_BAUD_CTRL, 8'h08);
      wr(OFS_TX_CTRL, 8'h04);
      // 8-bit mode, clk/128 counter: 5120 clocks give 40
      wr(OFS_BAUD_CTRL, 8'h01);
      fork
         node.send_frame(8'h55);
         begin
            repeat (2560) @(posedge clk_sys);
            chk(8'(rx_interrupt_flag), 8'h00);
            rc(OFS_BAUD_CTRL, 8'h41);
         end
      join
      chk(8'(rx_interrupt_flag), 8'h01);
      rc(OFS_BAUD_CTRL, 8'h40);
      rc(OFS_DIV_LO, 8'h28);
      rc(OFS_DIV_HI, 8'h00);
      rd(OFS_RX_DATA);
      chk(8'(rx_interrupt_flag), 8'h00);
      // wake and auto-baud together, 16-bit clk/32 counter
      rc(OFS_BAUD_CTRL, 8'h40);
      wr(OFS_BAUD_CTRL, 8'h0B);
      fork
         node.send_low(13);
         begin
            repeat (20) @(posedge clk_sys);
            chk(8'(rx_interrupt_flag), 8'h01);
            rd(OFS_BAUD_CTRL);
            chk(8'(d[1:0]), 8'h03);
         end
      join
      rd(OFS_BAUD_CTRL);
      chk(8'(d[1:0]), 8'h01);
      rd(OFS_RX_DATA);
      chk(8'(rx_interrupt_flag), 8'h00);
      node.send_frame(8'h55);
      chk(8'(rx_interrupt_flag), 8'h01);
      rc(OFS_BAUD_CTRL, 8'h48);
      rc(OFS_DIV_LO, 8'hA0);
      rc(OFS_DIV_HI, 8'h00);
      rd(OFS_RX_DATA);
      // break then preloaded sync byte on the transmit line
      wr(OFS_DIV_LO, 8'h9F);
      wr(OFS_TX_CTRL, 8'h2C);
      wr(OFS_TX_DATA, 8'hFF);
      wr(OFS_TX_DATA, 8'h55);
      repeat (1000) @(posedge clk_sys);
      rc(OFS_TX_CTRL, 8'h2C);
      while (node.got.size() < 2)
         @(posedge clk_sys);
      repeat (700) @(posedge clk_sys);
      chk(node.got[0][7:0], 8'h00);
      chk(8'(node.got[0][8]), 8'h00);
      chk(8'(node.max_low > 7680 && node.max_low <= 8320), 8'h01);
      chk(node.got[1][7:0], 8'h55);
      chk(8'(node.got[1][8]), 8'h01);
      rc(OFS_TX_CTRL, 8'h26);
      chk(8'(tx_buffer_empty_flag), 8'h01);
      results();
   end
endmodule
